// ==== verilog/ccs_pkg.sv ====
// =====================================================================
// Shared constants for the cell conversion sequencer and its controller.
// =====================================================================
package ccs_pkg;

  // Clock period of mclk_i in nanoseconds.
  localparam int CLK_NS = 50;

  // Control word layout.
  localparam int CTRL_W      = 16;
  localparam int CHSEL_HI    = 15;
  localparam int CHSEL_LO    = 14;
  localparam int ACQSEL_HI   = 6;
  localparam int ACQSEL_LO   = 5;
  localparam int CNV_CS_BIT  = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // Channel select field encodings.
  localparam logic [1:0] CHSEL_ALL   = 2'h0;
  localparam logic [1:0] CHSEL_ODD_T = 2'h1;
  localparam logic [1:0] CHSEL_VOLT  = 2'h2;
  localparam logic [1:0] CHSEL_TEST  = 2'h3;

  // Channel numbers on the multiplexer and result indices.
  localparam int CH_W = 4;
  localparam logic [CH_W-1:0] CH_CELL1 = 4'h0;
  localparam logic [CH_W-1:0] CH_CELL6 = 4'h5;
  localparam logic [CH_W-1:0] CH_TEMP1 = 4'h6;
  localparam logic [CH_W-1:0] CH_TEMP5 = 4'ha;
  localparam logic [CH_W-1:0] CH_TEMP6 = 4'hb;
  localparam logic [CH_W-1:0] CH_BGAP  = 4'hc;
  localparam logic [CH_W-1:0] CH_NONE  = 4'hf;
  localparam int NUM_RES = 13;
  localparam int CODE_W  = 12;

  // Acquisition and conversion timing.
  localparam int ACQ_STEP_NS  = 400;
  localparam int ACQ_STEP_CYC = (ACQ_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYC     = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 6;

  // Daisy chain forwarding delay and pulse width.
  localparam int CHAIN_DELAY_NS = 250;
  localparam int CHAIN_CYC      = (CHAIN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHAIN_PULSE_NS = 200;
  localparam int CHAIN_PULSE    = (CHAIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FWD_W          = 5;

  // Controller waits.
  localparam int SETTLE_US  = 90;
  localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W   = 11;
  localparam int TWAIT_US   = 5;
  localparam int TWAIT_CYC  = (TWAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TWAIT_W    = 7;
  localparam int SCLK_HALF  = 4;
  localparam int DIV_W      = 3;
  localparam int BITS_W     = 5;
  localparam int CNV_LOW_CYC = 8;

  // Link synchroniser slots in the device.
  localparam int SY_SCLK  = 0;
  localparam int SY_CS    = 1;
  localparam int SY_SDI   = 2;
  localparam int SY_CNV   = 3;
  localparam int SY_CHAIN = 4;
  localparam int SY_W     = 5;

  // Sequencer states of the device.
  typedef enum logic [1:0] {DS_IDLE, DS_CONV, DS_ACQ} ccs_dev_st_t;

  // Controller states.
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT} ccs_host_st_t;

endpackage

// ==== verilog/ccs_link_if.sv ====
`timescale 1ns/1ns
// =====================================================================
// Serial and start link between controller and device.
// =====================================================================
interface ccs_link_if;
  logic sclk;            // Serial clock made by the controller.
  logic cs_n;            // Chip select, active low.
  logic sdi;             // Serial control data, MSB first.
  logic convert_start_n; // Dedicated start pin, active low.
  logic busy;            // Device sequence in progress.

  // Controller end.
  modport host (output sclk, output cs_n, output sdi, output convert_start_n, input busy);
  // Device end.
  modport dev (input sclk, input cs_n, input sdi, input convert_start_n, output busy);
endinterface

// ==== verilog/ccs_device.sv ====
`timescale 1ns/1ns
module ccs_device
  import ccs_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // Link to the controller.
  ccs_link_if.dev                link,
  // Daisy chain start from below and to above.
  input  wire logic              chain_start_i,
  output logic                   chain_start_o,
  // Converter front end.
  input  wire logic [CODE_W-1:0] conv_code_i,
  output logic                   hold_o,
  output logic [CH_W-1:0]        mux_sel_o,
  output logic                   eoc_o,
  // Result readback.
  input  wire logic [CH_W-1:0]   rd_idx_i,
  output logic [CODE_W-1:0]      rd_data_o,
  // Current control word.
  output logic [CTRL_W-1:0]      ctrl_o
);

  // ===================================================================
  // State record
  // ===================================================================
  typedef struct packed {
    logic [SY_W-1:0]                  s1;    // First synchroniser stage.
    logic [SY_W-1:0]                  s2;    // Second synchroniser stage.
    logic [SY_W-1:0]                  prev;  // Delayed copy for edges.
    logic [CTRL_W-1:0]                shift; // Incoming control bits.
    logic [BITS_W-1:0]                bits;  // Bits seen in this frame.
    logic [CTRL_W-1:0]                ctrl;  // Active control word.
    ccs_dev_st_t                      st;    // Sequencer state.
    logic [CNT_W-1:0]                 cnt;   // Phase countdown.
    logic [CH_W-1:0]                  chan;  // Multiplexer selection.
    logic                             hold;  // Track-and-hold in hold.
    logic                             busy;  // Sequence running.
    logic                             eoc;   // End of conversion pulse.
    logic [NUM_RES-1:0][CODE_W-1:0]   res;   // Result store.
    logic [CODE_W-1:0]                rd;    // Registered read data.
    logic [FWD_W-1:0]                 fwd;   // Chain forward countdown.
    logic                             chain; // Chain start output.
  } ccs_dev_state_t;

  ccs_dev_state_t state_reg;   // Registered state.
  ccs_dev_state_t state_next;  // Next state.

  // ===================================================================
  // Channel order
  // ===================================================================
  // Returns the channel after cur for the given selection, or none.
  function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] cur,
                                                input logic [1:0]      sel);
    logic [CH_W-1:0] nx;
    nx = CH_NONE;
    if (cur > CH_CELL1 && cur <= CH_CELL6) begin
      // Cells walk downward.
      nx = cur - 4'h1;
    end else if (cur == CH_CELL1) begin
      // Temperatures follow unless voltages only were chosen.
      nx = (sel == CHSEL_ALL || sel == CHSEL_ODD_T) ? CH_TEMP1 : CH_NONE;
    end else if (sel == CHSEL_ALL && cur >= CH_TEMP1 && cur < CH_TEMP6) begin
      // Every temperature channel in ascending order.
      nx = cur + 4'h1;
    end else if (sel == CHSEL_ODD_T && cur >= CH_TEMP1 && cur < CH_TEMP5) begin
      // Temperatures one, three and five.
      nx = cur + 4'h2;
    end
    return nx;
  endfunction

  // ===================================================================
  // Next-state logic
  // ===================================================================
  logic                 sclk_rise;  // Serial clock rising edge.
  logic                 cs_rise;    // Chip select released.
  logic                 cs_fall;    // Chip select asserted.
  logic                 cnv_fall;   // Start pin falling edge.
  logic                 chain_rise; // Start from device below.
  logic                 cs_start;   // Start requested by control write.
  logic                 go;         // Any start request.
  logic [CNT_W-1:0]     acq_cyc;    // Acquisition length in cycles.
  logic [CH_W-1:0]      nx_chan;    // Channel after the current one.

  // Computes the whole next state from the current one and the inputs.
  always_comb begin
    state_next     = state_reg;
    state_next.s1  = {chain_start_i, link.convert_start_n, link.sdi, link.cs_n, link.sclk};
    state_next.s2  = state_reg.s1;
    state_next.prev = state_reg.s2;
    state_next.eoc = 1'b0;
    sclk_rise  = state_reg.s2[SY_SCLK] & ~state_reg.prev[SY_SCLK];
    cs_rise    = state_reg.s2[SY_CS] & ~state_reg.prev[SY_CS];
    cs_fall    = ~state_reg.s2[SY_CS] & state_reg.prev[SY_CS];
    cnv_fall   = ~state_reg.s2[SY_CNV] & state_reg.prev[SY_CNV];
    chain_rise = state_reg.s2[SY_CHAIN] & ~state_reg.prev[SY_CHAIN];
    cs_start   = 1'b0;
    nx_chan    = CH_NONE;

    // Serial control frame: bits enter on sclk rising while selected.
    if (cs_fall) begin
      state_next.bits = '0;
    end else if (sclk_rise && !state_reg.s2[SY_CS]) begin
      state_next.shift = {state_reg.shift[CTRL_W-2:0], state_reg.s2[SY_SDI]};
      if (state_reg.bits != BITS_W'(CTRL_W)) begin
        state_next.bits = state_reg.bits + 5'h1;
      end
    end
    // A complete word is taken when chip select rises.
    if (cs_rise && state_reg.bits == BITS_W'(CTRL_W)) begin
      state_next.ctrl = state_reg.shift;
      cs_start = state_reg.shift[CNV_CS_BIT];
    end

    go = cnv_fall | cs_start | chain_rise;
    acq_cyc = CNT_W'((32'(state_next.ctrl[ACQSEL_HI:ACQSEL_LO]) + 32'd1) * ACQ_STEP_CYC);

    // Sequencer.
    case (state_reg.st)
      DS_IDLE: begin
        state_next.hold = 1'b0;
        state_next.chan = CH_CELL6;
        if (go) begin
          state_next.hold = 1'b1;
          state_next.chan = (state_next.ctrl[CHSEL_HI:CHSEL_LO] == CHSEL_TEST) ?
                            CH_BGAP : CH_CELL6;
          state_next.cnt  = CNT_W'(CONV_CYC - 1);
          state_next.busy = 1'b1;
          state_next.st   = DS_CONV;
          state_next.fwd  = FWD_W'(CHAIN_CYC + CHAIN_PULSE);
        end
      end
      DS_CONV: begin
        if (state_reg.cnt == '0) begin
          state_next.res[state_reg.chan] = conv_code_i;
          state_next.eoc = 1'b1;
          state_next.hold = 1'b0;
          nx_chan = next_chan(state_reg.chan, state_reg.ctrl[CHSEL_HI:CHSEL_LO]);
          if (nx_chan == CH_NONE) begin
            state_next.chan = CH_CELL6;
            state_next.busy = 1'b0;
            state_next.st   = DS_IDLE;
          end else begin
            state_next.chan = nx_chan;
            state_next.cnt  = acq_cyc - 6'h1;
            state_next.st   = DS_ACQ;
          end
        end else begin
          state_next.cnt = state_reg.cnt - 6'h1;
        end
      end
      DS_ACQ: begin
        if (state_reg.cnt == '0) begin
          state_next.hold = 1'b1;
          state_next.cnt  = CNT_W'(CONV_CYC - 1);
          state_next.st   = DS_CONV;
        end else begin
          state_next.cnt = state_reg.cnt - 6'h1;
        end
      end
      default: begin
        state_next.st = DS_IDLE;
      end
    endcase

    // Chain output pulses once the forwarding delay has passed.
    // Only an accepted start reloads the count; one seen while busy must not stall it.
    if (state_reg.fwd != '0 && !(go && state_reg.st == DS_IDLE)) begin
      state_next.fwd = state_reg.fwd - 5'h1;
    end
    state_next.chain = (state_next.fwd != '0) && (state_next.fwd <= FWD_W'(CHAIN_PULSE));

    state_next.rd = (rd_idx_i < CH_W'(NUM_RES)) ? state_next.res[rd_idx_i] : '0;
  end

  // ===================================================================
  // State register
  // ===================================================================
  // Registers the whole state; reset puts the sequencer idle with the top cell selected.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg      <= '0;
      state_reg.s1   <= {SY_W{1'b1}};
      state_reg.s2   <= {SY_W{1'b1}};
      state_reg.prev <= {SY_W{1'b1}};
      state_reg.ctrl <= CTRL_RESET;
      state_reg.st   <= DS_IDLE;
      state_reg.chan <= CH_CELL6;
    end else begin
      state_reg <= state_next;
    end
  end

  // ===================================================================
  // Outputs
  // ===================================================================
  // Every output is a direct flip-flop copy.
  assign link.busy     = state_reg.busy;
  assign chain_start_o = state_reg.chain;
  assign hold_o        = state_reg.hold;
  assign mux_sel_o     = state_reg.chan;
  assign eoc_o         = state_reg.eoc;
  assign rd_data_o     = state_reg.rd;
  assign ctrl_o        = state_reg.ctrl;

endmodule

// ==== verilog/ccs_host.sv ====
`timescale 1ns/1ns
// =====================================================================
// System controller end: writes control words, starts sequences and
// keeps the settle and readback waits.
// =====================================================================
module ccs_host
  import ccs_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // Link to the device.
  ccs_link_if.host               link,
  // User command port.
  input  wire logic              cmd_write_i,
  input  wire logic [CTRL_W-1:0] cmd_word_i,
  input  wire logic              cmd_start_i,
  output logic                   cmd_ready_o,
  // Sequence status.
  output logic                   seq_busy_o,
  output logic                   read_ok_o
);

  // ===================================================================
  // State record
  // ===================================================================
  typedef struct packed {
    ccs_host_st_t          st;      // Serial engine state.
    logic [DIV_W-1:0]      div;     // Serial clock divider.
    logic [BITS_W-1:0]     bits;    // Bits sent.
    logic [CTRL_W-1:0]     word;    // Word being sent.
    logic [CTRL_W-1:0]     keep;    // Word to resend after settling.
    logic                  pend;    // Resend with start pending.
    logic                  chg;     // Frame changes acquisition time.
    logic [1:0]            acq;     // Last acquisition field written.
    logic [SETTLE_W-1:0]   settle;  // Settle countdown.
    logic [TWAIT_W-1:0]    wt;      // Readback wait countdown.
    logic [3:0]            low;     // Start pin low countdown.
    logic                  b1;      // Busy synchroniser stage one.
    logic                  b2;      // Busy synchroniser stage two.
    logic                  bp;      // Delayed busy for edges.
    logic                  sclk;    // Serial clock out.
    logic                  cs_n;    // Chip select out.
    logic                  sdi;     // Data out.
    logic                  cnv_n;   // Start pin out.
    logic                  ready;   // Command accepted next cycle.
    logic                  rok;     // Readback allowed.
  } ccs_host_state_t;

  ccs_host_state_t state_reg;   // Registered state.
  ccs_host_state_t state_next;  // Next state.

  // ===================================================================
  // Next-state logic
  // ===================================================================
  // Serial engine, waits and the start pin.
  always_comb begin
    state_next    = state_reg;
    state_next.b1 = link.busy;
    state_next.b2 = state_reg.b1;
    state_next.bp = state_reg.b2;
    if (state_reg.settle != '0) begin
      state_next.settle = state_reg.settle - 11'h1;
    end
    // Readback wait starts when the sequence ends.
    // readback wait start
    if (!state_reg.b2 && state_reg.bp) begin
      state_next.wt = TWAIT_W'(TWAIT_CYC);
    end else if (state_reg.wt != '0) begin
      state_next.wt = state_reg.wt - 7'h1;
    end
    // Start pin pulse.
    if (state_reg.low != '0) begin
      state_next.low = state_reg.low - 4'h1;
    end
    state_next.cnv_n = (state_next.low == '0);

    case (state_reg.st)
      HS_IDLE: begin
        if (state_reg.pend && state_reg.settle == '0 && !state_reg.b2) begin
          // Second write carries the start after settling.
          state_next.word = state_reg.keep;
          state_next.pend = 1'b0;
          state_next.chg  = 1'b0;
          state_next.st   = HS_SHIFT;
          state_next.cs_n = 1'b0;
          state_next.div  = '0;
          state_next.bits = '0;
        end else if (cmd_write_i && state_reg.ready) begin
          state_next.word = cmd_word_i;
          state_next.chg  = cmd_word_i[ACQSEL_HI:ACQSEL_LO] != state_reg.acq;
          state_next.acq  = cmd_word_i[ACQSEL_HI:ACQSEL_LO];
          if (state_next.chg && cmd_word_i[CNV_CS_BIT]) begin
            // Split into a setup write and a later start write.
            state_next.word[CNV_CS_BIT] = 1'b0;
            state_next.keep = cmd_word_i;
            state_next.pend = 1'b1;
          end
          state_next.st   = HS_SHIFT;
          state_next.cs_n = 1'b0;
          state_next.div  = '0;
          state_next.bits = '0;
        end else if (cmd_start_i && state_reg.ready) begin
          state_next.low   = 4'(CNV_LOW_CYC);
          state_next.cnv_n = 1'b0;
        end
      end
      HS_SHIFT: begin
        state_next.div = state_reg.div + 3'h1;
        if (state_reg.div == '0) begin
          if (state_reg.bits == BITS_W'(CTRL_W)) begin
            // Frame done; settle timer starts at its end if the frame changes the acquisition time.
            state_next.cs_n = 1'b1;
            state_next.st   = HS_IDLE;
            if (state_reg.chg) begin
              state_next.settle = SETTLE_W'(SETTLE_CYC);
            end
          end else begin
            state_next.sclk = 1'b0;
            state_next.sdi  = state_reg.word[CTRL_W-1];
            state_next.word = {state_reg.word[CTRL_W-2:0], 1'b0};
          end
        end else if (state_reg.div == DIV_W'(SCLK_HALF)) begin
          state_next.sclk = 1'b1;
          state_next.bits = state_reg.bits + 5'h1;
        end
      end
      default: begin
        state_next.st = HS_IDLE;
      end
    endcase

    state_next.ready = (state_next.st == HS_IDLE) && (state_next.settle == '0) &&
                       !state_next.pend && (state_next.low == '0) && !state_next.b2 &&
                       !(state_reg.st == HS_IDLE && (cmd_write_i || cmd_start_i) &&
                         state_reg.ready);
    state_next.rok = !state_next.b2 && (state_next.wt == '0) && !state_next.bp;
  end

  // ===================================================================
  // State register
  // ===================================================================
  // Registers the whole state; serial clock, chip select and start pin idle high after reset, data low.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg       <= '0;
      state_reg.st    <= HS_IDLE;
      state_reg.sclk  <= 1'b1;
      state_reg.cs_n  <= 1'b1;
      state_reg.cnv_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops.
  assign link.sclk            = state_reg.sclk;
  assign link.cs_n            = state_reg.cs_n;
  assign link.sdi             = state_reg.sdi;
  assign link.convert_start_n = state_reg.cnv_n;
  assign cmd_ready_o          = state_reg.ready;
  assign seq_busy_o           = state_reg.b2;
  assign read_ok_o            = state_reg.rok;

endmodule

// ==== tb/ccs_link_chk.sv ====
`timescale 1ns/1ns
// =====================================================================
// Checker on the link between controller and device.
// =====================================================================
module ccs_link_chk
  import ccs_pkg::*;
(
  // Clock, reset and link signals.
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  input  wire logic convert_start_n,
  input  wire logic busy
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [4:0] rises_reg; // Serial clock rises seen in the current frame.
  logic [9:0] busy_reg;  // Length of the current busy period.
  // Counters clear outside frames and outside sequences.
  always_ff @(posedge mclk_i) begin
    rises_reg <= (sys_rst_i || cs_n) ? 5'h00 : rises_reg + 5'($rose(sclk));
    busy_reg  <= (sys_rst_i || !busy) ? 10'h000 : busy_reg + 10'h001;
  end
  a_sclk_idle_high: assert property (cs_n |-> sclk) else $error("sclk low outside frame");
  a_frame_bits: assert property ($rose(cs_n) |-> rises_reg == 5'h10)
    else $error("frame not sixteen clocks");
  a_sdi_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdi) |-> !sclk)
    else $error("sdi moved while sclk high");
  a_start_out_frame: assert property (!cs_n |-> convert_start_n)
    else $error("start pin low inside a frame");
  a_start_width: assert property ($fell(convert_start_n) |-> !convert_start_n [*8] ##1 convert_start_n)
    else $error("start pulse not eight cycles");
  a_start_busy: assert property ($fell(convert_start_n) && !busy |-> ##[1:5] busy)
    else $error("busy missing after start");
  a_busy_min_len: assert property ($rose(busy) |-> busy [*8]) else $error("busy too short");
  a_busy_max_len: assert property (busy_reg < 10'h258) else $error("busy too long");
  a_frame_idle_dev: assert property ($fell(cs_n) |-> !busy) else $error("frame during busy");
endmodule

// ==== tb/cell_conversion_sequencer_bench.sv ====
`timescale 1ns/1ns
// =====================================================================
// Bench: controller and device joined over the link.
// =====================================================================
module cell_conversion_sequencer_bench;
  import ccs_pkg::*;
  logic              mclk_i = 1'b0;   // System clock.
  logic              sys_rst_i = 1'b1; // Reset, held at start.
  logic              cmd_write_i = 1'b0, cmd_start_i = 1'b0, chain_start_i = 1'b0;
  logic [CTRL_W-1:0] cmd_word_i = 16'h0000, ctrl_o;
  logic [CH_W-1:0]   rd_idx_i = 4'h0, mux_sel_o;
  logic [CODE_W-1:0] conv_code_i = 12'h000, rd_data_o;
  logic              cmd_ready_o, seq_busy_o, read_ok_o, chain_start_o, hold_o, eoc_o;
  logic [7:0]        salt = 8'h10;     // Run stamp in the converter codes.
  int                n_errors = 0, checked = 0;
  ccs_link_if link();
  ccs_host ccs_host_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.host),
    .cmd_write_i(cmd_write_i), .cmd_word_i(cmd_word_i), .cmd_start_i(cmd_start_i),
    .cmd_ready_o(cmd_ready_o), .seq_busy_o(seq_busy_o), .read_ok_o(read_ok_o));
  ccs_device ccs_device_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.dev),
    .chain_start_i(chain_start_i), .chain_start_o(chain_start_o), .conv_code_i(conv_code_i),
    .hold_o(hold_o), .mux_sel_o(mux_sel_o), .eoc_o(eoc_o), .rd_idx_i(rd_idx_i),
    .rd_data_o(rd_data_o), .ctrl_o(ctrl_o));
  ccs_link_chk ccs_link_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .sdi(link.sdi), .convert_start_n(link.convert_start_n), .busy(link.busy));
  // Clock, and a converter whose code names the channel and the run.
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) conv_code_i <= {salt, mux_sel_o};
  // Compares one value and reports a mismatch.
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One request on the command port once it is ready.
  task automatic issue(input logic [15:0] word, input logic start);
    while (cmd_ready_o !== 1'b1) @(negedge mclk_i);
    @(posedge mclk_i);
    cmd_write_i <= ~start;
    cmd_start_i <= start;
    cmd_word_i  <= word;
    @(posedge mclk_i);
    cmd_write_i <= 1'b0;
    cmd_start_i <= 1'b0;
    // Let the ready flag settle before anyone looks at it again.
    @(negedge mclk_i);
  endtask
  // Writes a word, starts by pin (0), chip select (1) or chain (2), checks it all.
  task automatic run(input logic [15:0] word, input int src);
    int k, tb, tf, tc, nc, ne, m, acq;
    logic hp;
    logic [3:0] got[$];
    logic [3:0] exp[$];
    time t0, ts;
    acq = (int'(word[6:5]) + 1) * ACQ_STEP_CYC;
    if (word[15:14] == CHSEL_TEST) exp.push_back(CH_BGAP);
    else begin
      for (int c = 5; c >= 0; c--) exp.push_back(4'(c));
      for (int c = 6; c < 12; c++)
        if (word[15:14] == CHSEL_ALL || (word[15:14] == CHSEL_ODD_T && c % 2 == 0))
          exp.push_back(4'(c));
    end
    salt = salt + 8'h11;
    m = (word[6:5] != ctrl_o[6:5]) ? SETTLE_CYC : 0;
    t0 = $time;
    issue(word, 1'b0);
    if (src == 0) issue(16'h0000, 1'b1);
    if (src == 2) while (cmd_ready_o !== 1'b1) @(negedge mclk_i);
    {k, tb, tf, tc, nc, hp} = {32'h0, -32'sh1, -32'sh1, -32'sh1, 32'h0, 1'b0};
    ne = 0;
    while (tf < 0 && k < 3000) begin
      @(posedge mclk_i);
      if (src == 2) chain_start_i <= (k < 4);
      @(negedge mclk_i);
      k++;
      if (link.busy === 1'b1 && tb < 0) {tb, ts} = {k, $time};
      if (hold_o === 1'b1 && !hp) got.push_back(mux_sel_o);
      hp = (hold_o === 1'b1);
      if (chain_start_o === 1'b1) nc++;
      if (eoc_o === 1'b1) ne++;
      if (chain_start_o === 1'b1 && tc < 0) tc = k;
      if (tb >= 0 && link.busy === 1'b0) tf = k;
    end
    cmp(16'((ts - t0) / CLK_NS >= m), 16'h1);
    cmp(16'(tf - tb), 16'((acq + CONV_CYC) * exp.size() - acq));
    cmp(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) cmp({12'h0, got[i]}, {12'h0, exp[i]});
    cmp(16'(ne), 16'(exp.size()));
    cmp({8'h0, mux_sel_o, 3'h0, hold_o}, {8'h0, CH_CELL6, 4'h0});
    cmp(ctrl_o, word);
    cmp(16'(tc - tb), 16'(CHAIN_CYC));
    cmp(16'(nc), 16'(CHAIN_PULSE));
    for (m = 0; m < 300 && read_ok_o !== 1'b1; m++) @(negedge mclk_i);
    cmp(16'(m >= TWAIT_CYC), 16'h1);
    cmp({15'h0, seq_busy_o}, 16'h0);
    exp.push_back(4'hd);
    foreach (exp[i]) begin
      @(posedge mclk_i);
      rd_idx_i <= exp[i];
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      cmp({4'h0, rd_data_o}, (exp[i] > CH_BGAP) ? 16'h0 : {4'h0, salt, exp[i]});
    end
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    #(40000 * CLK_NS);
    n_errors++;
    finish_test();
  end
  // Reset, defaults, then every channel set, start source and timing.
  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(negedge mclk_i);
    cmp({12'h0, mux_sel_o}, {12'h0, CH_CELL6});
    cmp(ctrl_o, CTRL_RESET);
    run(16'h0000, 0);
    run(16'h4020, 0);
    run(16'h8040, 0);
    run(16'hc060, 0);
    run(16'h8001, 1);
    run(16'hc060, 2);
    run(16'h0000, 2);
    finish_test();
  end
endmodule
